// ### hw/ppxi_map.svh
// Contract
// R1: Each port bit is input when direction bit clear, driven output when set.
// R2: Written output data bit holds on its pin until software rewrites it.
// R3: Output latch loads bus data only on write strobe addressing its data register.
// R4: Reading a data register returns sampled pin level for every input bit.
// R5: Each bit owns a pull-up enable that alone connects the pull-up.
// R6: Undriven input with pull-up connected reads back as one.
// R7: Port 2 bits 0 and 1 are interrupts zero and one, enable gated.
// R8: Port 3 bits 0 and 1 are interrupts two and three, enable gated.
// R9: Each interrupt has a two-bit trigger field in its port mode register.
// R10: Trigger field 00 fires the interrupt on a falling pin edge.
// R11: Port 2 bits 2 and 5 carry modulator outputs when their enables are set.
// R12: Software clears direction, sets pull-up, then programs falling-edge trigger.
// R13: Trigger 01 means rising edge; 10 and 11 mean any pin change.
// R14: Port 3 mode bits 3:2 trigger interrupt three, bits 1:0 interrupt two.
// R15: Trigger sets sticky flag; request needs own enable and global enable.
`ifndef PPXI_MAP_SVH
`define PPXI_MAP_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PPXI_ADR_FLAGS   8'h06
`define PPXI_ADR_ENABLE  8'h07
`define PPXI_ADR_P2_DATA 8'h24
`define PPXI_ADR_P2_DIR  8'h25
`define PPXI_ADR_P2_PU   8'h26
`define PPXI_ADR_P2_MODE 8'h27
`define PPXI_ADR_P3_DATA 8'h28
`define PPXI_ADR_P3_DIR  8'h29
`define PPXI_ADR_P3_PU   8'h2a
`define PPXI_ADR_P3_MODE 8'h2b
// ----------------------------------------
// Fields and constants
// ----------------------------------------
`define PPXI_GIE_BIT     7
`define PPXI_BZ_BIT      7
`define PPXI_PM2_BIT     6
`define PPXI_PM1_BIT     5
`define PPXI_PFO_BIT     4
`define PPXI_PDM1_PIN    2
`define PPXI_PDM2_PIN    5
`define PPXI_TRIG_A      1:0
`define PPXI_TRIG_B      3:2
`define PPXI_P3_MODE     4:0
`define PPXI_LOW_NIB     3:0
`define PPXI_SYNC_P2     7:0
`define PPXI_SYNC_P3     11:8
`define PPXI_IRQ_P2      1:0
`define PPXI_IRQ_P3      9:8
`define PPXI_ZERO_BYTE   8'h00
`define PPXI_ZERO_NIB    4'h0
`define PPXI_ZERO_TRI    3'h0
`define PPXI_SETTLE_DONE 2'h3
`define PPXI_SETTLE_STEP 2'h1
`endif

// ### hw/ppxi_pkg.sv
`include "ppxi_map.svh"
package ppxi_pkg;
   typedef enum logic [1:0] {TRIG_FALL, TRIG_RISE, TRIG_ANY_A, TRIG_ANY_B} ppxi_trig_t;
   typedef struct packed {
      logic [11:0] s1;
      logic [11:0] s2;
   } ppxi_sync_t;
   typedef struct packed {
      logic [3:0]  prev;
      logic [1:0]  settle;
   } ppxi_edge_t;
   typedef struct packed {
      logic [7:0]  port2_data;
      logic [7:0]  port2_direction;
      logic [7:0]  port2_pullup;
      logic [7:0]  port2_pin_mode;
      logic [3:0]  port3_data;
      logic [3:0]  port3_direction;
      logic [3:0]  port3_pullup;
      logic [4:0]  port3_pin_mode;
      logic [3:0]  ext_irq_flags;
      logic [3:0]  irq_en;
      logic        global_irq_enable;
      logic [7:0]  p2_out;
      logic [7:0]  p2_oe;
      logic [3:0]  p3_out;
      logic [3:0]  p3_oe;
      logic [7:0]  rdata;
      logic        irq;
   } ppxi_core_t;
endpackage : ppxi_pkg

// ### hw/ppxi_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ppxi_link_if;
   logic [11:0] pin_raw;
   logic [11:0] pin_sync;
   logic [3:0]  irq_level;
   logic [7:0]  trig_mode;
   logic [3:0]  trig_hit;
   modport sync_mp (input pin_raw, output pin_sync);
   modport edge_mp (input irq_level, input trig_mode, output trig_hit);
endinterface : ppxi_link_if
`default_nettype wire

// ### hw/ppxi_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ppxi_sync (
   // Clock and reset
   input  wire logic      mclk_in,
   input  wire logic      rstn_in,
   // Pin levels
   ppxi_link_if.sync_mp   link
);
   ppxi_pkg::ppxi_sync_t r;
   ppxi_pkg::ppxi_sync_t n;

   // First stage feeds only the second
   always_comb begin
      n    = r;
      n.s1 = link.pin_raw;
      n.s2 = r.s1;
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign link.pin_sync = r.s2;
endmodule : ppxi_sync
`default_nettype wire

// ### hw/ppxi_edge.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppxi_map.svh"
module ppxi_edge (
   // Clock and reset
   input  wire logic      mclk_in,
   input  wire logic      rstn_in,
   // Levels, modes, hits
   ppxi_link_if.edge_mp   link
);
   ppxi_pkg::ppxi_edge_t r;
   ppxi_pkg::ppxi_edge_t n;
   logic                 armed;
   logic [3:0]           rose;
   logic [3:0]           fell;

   function automatic logic trig_fire(input ppxi_pkg::ppxi_trig_t m,
                                      input logic rs, input logic fl);
      logic f;
      f = 1'b0;
      unique case (m)
         ppxi_pkg::TRIG_FALL:  f = fl;
         ppxi_pkg::TRIG_RISE:  f = rs;
         ppxi_pkg::TRIG_ANY_A: f = rs | fl;
         ppxi_pkg::TRIG_ANY_B: f = rs | fl;
      endcase
      return f;
   endfunction : trig_fire

   // Settle guard hides the reset-to-pin ramp
   always_comb begin
      n      = r;
      n.prev = link.irq_level;
      if (r.settle != `PPXI_SETTLE_DONE) begin
         n.settle = r.settle + `PPXI_SETTLE_STEP;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign armed = (r.settle == `PPXI_SETTLE_DONE);
   assign rose  = link.irq_level & ~r.prev;
   assign fell  = ~link.irq_level & r.prev;

   for (genvar i = 0; i < 4; i++) begin : g_chan
      // R10 R13 trigger decode
      assign link.trig_hit[i] = armed &
         trig_fire(ppxi_pkg::ppxi_trig_t'(link.trig_mode[2*i+1 -: 2]), rose[i], fell[i]);
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   property p_fall_fires;
      armed && link.trig_mode[`PPXI_TRIG_A] == 2'h0 && $fell(link.irq_level[0])
         |-> link.trig_hit[0];
   endproperty
   a_fall_fires: assert property (p_fall_fires) // R10
      else $error("falling edge missed");

   property p_rise_only;
      link.trig_mode[`PPXI_TRIG_B] == 2'h1 && link.trig_hit[1] |-> $rose(link.irq_level[1]);
   endproperty
   a_rise_only: assert property (p_rise_only) // R13
      else $error("rising mode fired without rise");
endmodule : ppxi_edge
`default_nettype wire

// ### hw/ppxi_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppxi_map.svh"
module ppxi_core (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   // Internal data bus
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   // Port two pins
   input  wire logic [7:0] p2_pin_in,
   output logic      [7:0] p2_pin_out,
   output logic      [7:0] p2_pin_oe_out,
   output logic      [7:0] p2_pullup_out,
   // Port three pins
   input  wire logic [3:0] p3_pin_in,
   output logic      [3:0] p3_pin_out,
   output logic      [3:0] p3_pin_oe_out,
   output logic      [3:0] p3_pullup_out,
   // Modulator sources
   input  wire logic       pdm_one_in,
   input  wire logic       pdm_two_in,
   // Side controls and request
   output logic            irq_out,
   output logic            buzzer_enable_out,
   output logic            prog_counter_enable_out
);
   // ----------------------------------------
   // State and links
   // ----------------------------------------
   ppxi_pkg::ppxi_core_t r;
   ppxi_pkg::ppxi_core_t n;
   logic [7:0]           p2_sync;
   logic [3:0]           p3_sync;
   logic [7:0]           pdm_mask;

   ppxi_link_if link ();

   ppxi_sync u_sync (
      .mclk_in (mclk_in),
      .rstn_in (rstn_in),
      .link    (link)
   );

   ppxi_edge u_edge (
      .mclk_in (mclk_in),
      .rstn_in (rstn_in),
      .link    (link)
   );

   assign link.pin_raw   = {p3_pin_in, p2_pin_in};
   assign p2_sync        = link.pin_sync[`PPXI_SYNC_P2];
   assign p3_sync        = link.pin_sync[`PPXI_SYNC_P3];
   // R7 R8 interrupt pin taps
   assign link.irq_level = {link.pin_sync[`PPXI_IRQ_P3], link.pin_sync[`PPXI_IRQ_P2]};
   // R9 R14 trigger field routing
   assign link.trig_mode = {r.port3_pin_mode[`PPXI_TRIG_B], r.port3_pin_mode[`PPXI_TRIG_A],
                            r.port2_pin_mode[`PPXI_TRIG_B], r.port2_pin_mode[`PPXI_TRIG_A]};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n        = r;
      pdm_mask = `PPXI_ZERO_BYTE;
      // R3 addressed write only
      if (wr_in) begin
         case (addr_in)
            `PPXI_ADR_FLAGS:   n.ext_irq_flags   = wdata_in[`PPXI_LOW_NIB];
            `PPXI_ADR_ENABLE: begin
               n.irq_en = wdata_in[`PPXI_LOW_NIB];
               n.global_irq_enable    = wdata_in[`PPXI_GIE_BIT];
            end
            `PPXI_ADR_P2_DATA: n.port2_data      = wdata_in;
            `PPXI_ADR_P2_DIR:  n.port2_direction = wdata_in;
            `PPXI_ADR_P2_PU:   n.port2_pullup    = wdata_in;
            `PPXI_ADR_P2_MODE: n.port2_pin_mode  = wdata_in;
            `PPXI_ADR_P3_DATA: n.port3_data      = wdata_in[`PPXI_LOW_NIB];
            `PPXI_ADR_P3_DIR:  n.port3_direction = wdata_in[`PPXI_LOW_NIB];
            `PPXI_ADR_P3_PU:   n.port3_pullup    = wdata_in[`PPXI_LOW_NIB];
            `PPXI_ADR_P3_MODE: n.port3_pin_mode  = wdata_in[`PPXI_P3_MODE];
            default: ;
         endcase
      end
      // R15 sticky flags, set wins
      n.ext_irq_flags = n.ext_irq_flags | link.trig_hit;
      // R15 gated request
      n.irq = r.global_irq_enable && |(r.ext_irq_flags & r.irq_en);
      // R1 R2 direction and latch
      n.p2_out = r.port2_data;
      n.p2_oe  = r.port2_direction;
      n.p3_out = r.port3_data;
      n.p3_oe  = r.port3_direction;
      // R11 modulator takeover
      pdm_mask[`PPXI_PDM1_PIN] = r.port2_pin_mode[`PPXI_PM1_BIT];
      pdm_mask[`PPXI_PDM2_PIN] = r.port2_pin_mode[`PPXI_PM2_BIT];
      if (pdm_mask[`PPXI_PDM1_PIN]) begin
         n.p2_out[`PPXI_PDM1_PIN] = pdm_one_in;
         n.p2_oe[`PPXI_PDM1_PIN]  = 1'b1;
      end
      if (pdm_mask[`PPXI_PDM2_PIN]) begin
         n.p2_out[`PPXI_PDM2_PIN] = pdm_two_in;
         n.p2_oe[`PPXI_PDM2_PIN]  = 1'b1;
      end
      // R4 R6 input bits read pin
      if (rd_in) begin
         case (addr_in)
            `PPXI_ADR_FLAGS:   n.rdata = {`PPXI_ZERO_NIB, r.ext_irq_flags};
            `PPXI_ADR_ENABLE:  n.rdata = {r.global_irq_enable, `PPXI_ZERO_TRI, r.irq_en};
            `PPXI_ADR_P2_DATA: n.rdata = (r.port2_direction & r.port2_data) |
                                         (~r.port2_direction & p2_sync);
            `PPXI_ADR_P2_DIR:  n.rdata = r.port2_direction;
            `PPXI_ADR_P2_PU:   n.rdata = r.port2_pullup;
            `PPXI_ADR_P2_MODE: n.rdata = r.port2_pin_mode;
            `PPXI_ADR_P3_DATA: n.rdata = {`PPXI_ZERO_NIB, (r.port3_direction & r.port3_data) |
                                         (~r.port3_direction & p3_sync)};
            `PPXI_ADR_P3_DIR:  n.rdata = {`PPXI_ZERO_NIB, r.port3_direction};
            `PPXI_ADR_P3_PU:   n.rdata = {`PPXI_ZERO_NIB, r.port3_pullup};
            `PPXI_ADR_P3_MODE: n.rdata = {`PPXI_ZERO_TRI, r.port3_pin_mode};
            default:           n.rdata = `PPXI_ZERO_BYTE;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata_out               = r.rdata;
   assign p2_pin_out              = r.p2_out;
   assign p2_pin_oe_out           = r.p2_oe;
   assign p3_pin_out              = r.p3_out;
   assign p3_pin_oe_out           = r.p3_oe;
   // R5 per-bit pull-up
   assign p2_pullup_out           = r.port2_pullup;
   assign p3_pullup_out           = r.port3_pullup;
   assign irq_out                 = r.irq;
   assign buzzer_enable_out       = r.port2_pin_mode[`PPXI_BZ_BIT];
   assign prog_counter_enable_out = r.port3_pin_mode[`PPXI_PFO_BIT];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   // R1 direction drives enable
   property p_dir_follow;
      1'b1 |=> (p2_pin_oe_out & ~$past(pdm_mask)) ==
               ($past(r.port2_direction) & ~$past(pdm_mask))
               && p3_pin_oe_out == $past(r.port3_direction);
   endproperty
   a_dir_follow: assert property (p_dir_follow) // R1
      else $error("pin enable differs from direction");

   // R2 latch holds
   property p_latch_hold;
      !(wr_in && addr_in == `PPXI_ADR_P2_DATA) |=> $stable(r.port2_data);
   endproperty
   a_latch_hold: assert property (p_latch_hold) // R2
      else $error("port two latch moved without write");

   // R2 pin shows latch
   property p_pin_shows_latch;
      wr_in && addr_in == `PPXI_ADR_P3_DATA
         |=> ##1 p3_pin_out == $past(wdata_in[`PPXI_LOW_NIB], 2);
   endproperty
   a_pin_shows_latch: assert property (p_pin_shows_latch) // R2
      else $error("port three pin lost written value");

   // R3 capture on strobe
   property p_latch_load;
      wr_in && addr_in == `PPXI_ADR_P2_DATA |=> r.port2_data == $past(wdata_in);
   endproperty
   a_latch_load: assert property (p_latch_load) // R3
      else $error("port two latch missed write");

   // R4 input read-back
   property p_read_input;
      rd_in && addr_in == `PPXI_ADR_P2_DATA
         |=> (rdata_out & ~$past(r.port2_direction)) ==
             ($past(p2_sync) & ~$past(r.port2_direction));
   endproperty
   a_read_input: assert property (p_read_input) // R4
      else $error("input bit read does not match pin");

   // R5 pull-up write
   property p_pullup_write;
      wr_in && addr_in == `PPXI_ADR_P3_PU
         |=> p3_pullup_out == $past(wdata_in[`PPXI_LOW_NIB]) ##1 $stable(p3_pullup_out)
             || $past(wr_in && addr_in == `PPXI_ADR_P3_PU);
   endproperty
   a_pullup_write: assert property (p_pullup_write) // R5
      else $error("pull-up enable not taken");

   // R6 pulled input reads one
   property p_pulled_one;
      rd_in && addr_in == `PPXI_ADR_P3_DATA && r.port3_pullup[0] && !r.port3_direction[0]
         && p3_sync[0] |=> rdata_out[0];
   endproperty
   a_pulled_one: assert property (p_pulled_one) // R6
      else $error("pulled-up input read low");

   // R7 interrupt zero flag
   property p_flag_zero;
      link.trig_hit[0] |=> r.ext_irq_flags[0];
   endproperty
   a_flag_zero: assert property (p_flag_zero) // R7
      else $error("interrupt zero flag not set");

   // R8 interrupt three flag
   property p_flag_three;
      link.trig_hit[3] |=> r.ext_irq_flags[3];
   endproperty
   a_flag_three: assert property (p_flag_three) // R8
      else $error("interrupt three flag not set");

   // R9 R14 port three field placement
   property p_p3_field;
      wr_in && addr_in == `PPXI_ADR_P3_MODE
         |=> link.trig_mode[7:6] == $past(wdata_in[`PPXI_TRIG_B])
             && link.trig_mode[5:4] == $past(wdata_in[`PPXI_TRIG_A]);
   endproperty
   a_p3_field: assert property (p_p3_field) // R14
      else $error("port three trigger field misplaced");

   // R9 port two field placement
   property p_p2_field;
      wr_in && addr_in == `PPXI_ADR_P2_MODE
         |=> link.trig_mode[3:0] == $past(wdata_in[`PPXI_LOW_NIB]);
   endproperty
   a_p2_field: assert property (p_p2_field) // R9
      else $error("port two trigger field misplaced");

   // R11 modulator drives pin
   property p_pdm_one;
      r.port2_pin_mode[`PPXI_PM1_BIT]
         |=> p2_pin_oe_out[`PPXI_PDM1_PIN] && p2_pin_out[`PPXI_PDM1_PIN] == $past(pdm_one_in);
   endproperty
   a_pdm_one: assert property (p_pdm_one) // R11
      else $error("modulator one not on pin");

   // R11 ordinary I/O when off
   property p_pdm_two_off;
      !r.port2_pin_mode[`PPXI_PM2_BIT]
         |=> p2_pin_out[`PPXI_PDM2_PIN] == $past(r.port2_data[`PPXI_PDM2_PIN]);
   endproperty
   a_pdm_two_off: assert property (p_pdm_two_off) // R11
      else $error("bit five not ordinary I/O");

   // R15 request gating
   property p_irq_gate;
      1'b1 |=> irq_out == ($past(r.global_irq_enable) && |($past(r.ext_irq_flags) & $past(r.irq_en)));
   endproperty
   a_irq_gate: assert property (p_irq_gate) // R15
      else $error("interrupt request gating wrong");

   // R15 flag sticky
   property p_flag_sticky;
      r.ext_irq_flags[1] && !(wr_in && addr_in == `PPXI_ADR_FLAGS) |=> r.ext_irq_flags[1];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // R15
      else $error("flag dropped without clear");

   // R15 set beats clear
   property p_set_wins;
      wr_in && addr_in == `PPXI_ADR_FLAGS && link.trig_hit[2] |=> r.ext_irq_flags[2];
   endproperty
   a_set_wins: assert property (p_set_wins) // R15
      else $error("event lost under clear");

   // R7 interrupt one flag
   property p_flag_one;
      link.trig_hit[1] |=> r.ext_irq_flags[1];
   endproperty
   a_flag_one: assert property (p_flag_one) // R7
      else $error("interrupt one flag not set");

   // R8 interrupt two flag
   property p_flag_two;
      link.trig_hit[2] |=> r.ext_irq_flags[2];
   endproperty
   a_flag_two: assert property (p_flag_two) // R8
      else $error("interrupt two flag not set");

   // R4 read data holds
   property p_rdata_hold;
      !rd_in |=> $stable(rdata_out);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) // R4
      else $error("read data moved without read");

   // R4 port three read-back
   property p_read_input_p3;
      rd_in && addr_in == `PPXI_ADR_P3_DATA
         |=> (rdata_out[`PPXI_LOW_NIB] & ~$past(r.port3_direction)) ==
             ($past(p3_sync) & ~$past(r.port3_direction));
   endproperty
   a_read_input_p3: assert property (p_read_input_p3) // R4
      else $error("port three input read does not match pin");

   // R11 modulator two drives pin
   property p_pdm_two;
      r.port2_pin_mode[`PPXI_PM2_BIT]
         |=> p2_pin_oe_out[`PPXI_PDM2_PIN] && p2_pin_out[`PPXI_PDM2_PIN] == $past(pdm_two_in);
   endproperty
   a_pdm_two: assert property (p_pdm_two) // R11
      else $error("modulator two not on pin");

   // R11 bit two ordinary
   property p_pdm_one_off;
      !r.port2_pin_mode[`PPXI_PM1_BIT]
         |=> p2_pin_out[`PPXI_PDM1_PIN] == $past(r.port2_data[`PPXI_PDM1_PIN]);
   endproperty
   a_pdm_one_off: assert property (p_pdm_one_off) // R11
      else $error("bit two not ordinary I/O");

   // R5 port two pull-up
   property p_pullup_p2;
      wr_in && addr_in == `PPXI_ADR_P2_PU |=> p2_pullup_out == $past(wdata_in);
   endproperty
   a_pullup_p2: assert property (p_pullup_p2) // R5
      else $error("port two pull-up not taken");

   // R3 port three capture
   property p_latch_load_p3;
      wr_in && addr_in == `PPXI_ADR_P3_DATA
         |=> r.port3_data == $past(wdata_in[`PPXI_LOW_NIB]);
   endproperty
   a_latch_load_p3: assert property (p_latch_load_p3) // R3
      else $error("port three latch missed write");

   // R2 port three holds
   property p_latch_hold_p3;
      !(wr_in && addr_in == `PPXI_ADR_P3_DATA) |=> $stable(r.port3_data);
   endproperty
   a_latch_hold_p3: assert property (p_latch_hold_p3) // R2
      else $error("port three latch moved without write");
endmodule : ppxi_core
`default_nettype wire

// ### verif/ppxi_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Far side of both ports
// ----------------------------------------
module ppxi_pins_model (
   // Clock
   input  wire logic        mclk_in,
   // Device drive
   input  wire logic [11:0] drv_in,
   input  wire logic [11:0] oe_in,
   input  wire logic [11:0] pullup_in,
   // External sources
   input  wire logic [11:0] ext_en_in,
   input  wire logic [11:0] ext_val_in,
   // Resolved pin levels
   output logic      [11:0] pin_out
);
   logic [11:0] float_r = 12'h5a5;
   // Floating pins never keep a value
   always @(posedge mclk_in) begin
      float_r <= ~float_r;
   end
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         if (oe_in[i]) begin
            pin_out[i] = drv_in[i];
         end else if (ext_en_in[i]) begin
            pin_out[i] = ext_val_in[i];
         end else if (pullup_in[i]) begin
            pin_out[i] = 1'b1;
         end else begin
            pin_out[i] = float_r[i];
         end
      end
   end
endmodule : ppxi_pins_model
`default_nettype wire

// ### verif/ppxi_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ppxi_core_tb;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic        mclk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic [7:0]  addr_in = 8'h00;
   logic [7:0]  wdata_in = 8'h00;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic        pdm_one_in = 1'b0;
   logic        pdm_two_in = 1'b0;
   logic [11:0] ext_en = 12'h000;
   logic [11:0] ext_val = 12'h000;
   logic [7:0]  rdata_out, p2_pin_out, p2_pin_oe_out, p2_pullup_out;
   logic [3:0]  p3_pin_out, p3_pin_oe_out, p3_pullup_out;
   logic        irq_out, buzzer_enable_out, prog_counter_enable_out;
   wire logic [11:0] pin_lvl;
   int          num_errors = 0;
   int          checked = 0;
   always #2 mclk_in = ~mclk_in;
   ppxi_core u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .p2_pin_in(pin_lvl[7:0]), .p2_pin_out(p2_pin_out), .p2_pin_oe_out(p2_pin_oe_out),
      .p2_pullup_out(p2_pullup_out), .p3_pin_in(pin_lvl[11:8]), .p3_pin_out(p3_pin_out),
      .p3_pin_oe_out(p3_pin_oe_out), .p3_pullup_out(p3_pullup_out),
      .pdm_one_in(pdm_one_in), .pdm_two_in(pdm_two_in), .irq_out(irq_out),
      .buzzer_enable_out(buzzer_enable_out),
      .prog_counter_enable_out(prog_counter_enable_out));
   ppxi_pins_model u_pins (.mclk_in(mclk_in), .drv_in({p3_pin_out, p2_pin_out}),
      .oe_in({p3_pin_oe_out, p2_pin_oe_out}), .pullup_in({p3_pullup_out, p2_pullup_out}),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pin_lvl));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Idle cycle after each strobe so it never re-asserts in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_in = a;
      wdata_in = d;
      wr_in = 1'b1;
      cyc(1);
      wr_in = 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
      addr_in = a;
      rd_in = 1'b1;
      cyc(1);
      rd_in = 1'b0;
      cyc(1);
      chk(nm, exp, rdata_out);
   endtask : rd_chk
   task automatic irq_case(input int i, input logic [1:0] m);
      logic [7:0] madr;
      logic [7:0] mval;
      logic [7:0] bit_i;
      int         p;
      madr = (i < 2) ? 8'h27 : 8'h2b;
      mval = (i % 2 == 1) ? {4'h0, m, 2'h0} : {6'h0, m};
      bit_i = 8'h01 << i;
      p = (i < 2) ? i : i + 6;
      wr(madr, mval);
      wr(8'h06, 8'h00);
      ext_val[p] = 1'b0;
      cyc(6);
      rd_chk(8'h06, (m != 2'h1) ? bit_i : 8'h00, "flag_fall");
      chk("irq_fall", {7'h0, m != 2'h1}, {7'h0, irq_out});
      wr(8'h06, 8'h00);
      ext_val[p] = 1'b1;
      cyc(6);
      rd_chk(8'h06, (m != 2'h0) ? bit_i : 8'h00, "flag_rise");
      wr(8'h06, 8'h00);
   endtask : irq_case
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [7:0] ra [9];
      ra = '{8'h06, 8'h07, 8'h25, 8'h26, 8'h27, 8'h29, 8'h2a, 8'h2b, 8'h3c};
      cyc(3);
      rstn_in = 1'b1;
      chk("oe_reset", 8'h00, p2_pin_oe_out);
      wr(8'h3c, 8'hff);
      foreach (ra[k]) rd_chk(ra[k], 8'h00, "reset_value");
      $display("test reset done");
      ext_en = 12'hcf0;
      ext_val = 12'h430;
      wr(8'h24, 8'ha5);
      wr(8'h25, 8'h0f);
      chk("p2_oe", 8'h0f, p2_pin_oe_out);
      chk("p2_out", 8'h05, p2_pin_out & 8'h0f);
      rd_chk(8'h24, 8'h35, "p2_read");
      wr(8'h23, 8'hff);
      wr(8'h26, 8'h00);
      chk("p2_hold", 8'h05, p2_pin_out & p2_pin_oe_out);
      wr(8'h28, 8'hfa);
      wr(8'h29, 8'hf3);
      rd_chk(8'h29, 8'h03, "p3_dir");
      chk("p3_out", 8'h02, {4'h0, p3_pin_out & p3_pin_oe_out});
      rd_chk(8'h28, 8'h06, "p3_read");
      $display("test data done");
      ext_en = 12'h000;
      wr(8'h25, 8'h00);
      wr(8'h29, 8'h00);
      wr(8'h26, 8'hff);
      wr(8'h2a, 8'hff);
      // Pull-up reaches a read only after both sync stages
      cyc(1);
      rd_chk(8'h24, 8'hff, "p2_pullup_read");
      rd_chk(8'h28, 8'h0f, "p3_pullup_read");
      chk("p3_pullup", 8'h0f, {4'h0, p3_pullup_out});
      ext_en = 12'h0f0;
      ext_val = 12'h000;
      wr(8'h26, 8'h0f);
      chk("p2_pullup", 8'h0f, p2_pullup_out);
      rd_chk(8'h24, 8'h0f, "p2_pullup_bits");
      $display("test pullup done");
      ext_en = 12'h000;
      pdm_one_in = 1'b1;
      wr(8'h27, 8'he0);
      wr(8'h2b, 8'h10);
      chk("pdm_oe", 8'h24, p2_pin_oe_out & 8'h24);
      chk("pdm_out_a", 8'h04, p2_pin_out & 8'h24);
      pdm_one_in = 1'b0;
      pdm_two_in = 1'b1;
      cyc(2);
      chk("pdm_out_b", 8'h20, p2_pin_out & 8'h24);
      chk("side_en", 8'h03, {6'h0, buzzer_enable_out, prog_counter_enable_out});
      rd_chk(8'h2b, 8'h10, "p3_mode");
      wr(8'h27, 8'h00);
      chk("pdm_off", 8'h00, p2_pin_oe_out);
      $display("test modulator done");
      ext_val = 12'h303;
      ext_en = 12'h303;
      wr(8'h25, 8'h00);
      wr(8'h26, 8'h03);
      wr(8'h2b, 8'h00);
      wr(8'h07, 8'h8f);
      cyc(6);
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 4; m++) irq_case(i, m[1:0]);
      end
      wr(8'h27, 8'h00);
      wr(8'h07, 8'h8e);
      ext_val[0] = 1'b0;
      cyc(6);
      rd_chk(8'h06, 8'h01, "flag_masked");
      chk("irq_masked", 8'h00, {7'h0, irq_out});
      wr(8'h07, 8'h0f);
      chk("irq_no_global", 8'h00, {7'h0, irq_out});
      wr(8'h07, 8'h81);
      chk("irq_enabled", 8'h01, {7'h0, irq_out});
      wr(8'h06, 8'h00);
      cyc(1);
      chk("irq_cleared", 8'h00, {7'h0, irq_out});
      // Pin event lands on the same edge as the clear
      ext_val[8] = 1'b0;
      cyc(2);
      wr(8'h06, 8'h00);
      rd_chk(8'h06, 8'h04, "flag_set_wins");
      $display("test interrupts done");
      tally_and_finish();
   end
   initial begin
      #200000;
      num_errors++;
      tally_and_finish();
   end
endmodule : ppxi_core_tb
`default_nettype wire
